// ---- design/gpp_pin_sync.sv ----
/*
 * Three-stage synchroniser for the pin levels, with a change accepted
 * once the second and third stages agree.
 * Assumes pins are asynchronous to pclk.
 */
`timescale 1ns/100ps
module gpp_pin_sync #(
    parameter int unsigned WIDTH = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Raw pins and filtered result
    input wire logic [WIDTH-1:0] pin_raw,
    output logic [WIDTH-1:0] pin_level
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync2_q;
    logic [WIDTH-1:0] sync3_q;
    logic [WIDTH-1:0] level_q;

    // First stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            meta_q <= pin_raw;
            sync2_q <= meta_q;
            sync3_q <= sync2_q;
        end
    end

    // Per-bit agreement filter
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    level_q[i] <= 1'b0;
                end else if (sync2_q[i] == sync3_q[i]) begin
                    level_q[i] <= sync3_q[i];
                end
            end
        end
    endgenerate

    assign pin_level = level_q;

endmodule : gpp_pin_sync

// ---- design/gpp_pkg.sv ----
/*
 * Package for the general purpose I/O port: register offsets, field
 * layout, reset values and the pin carrier types.
 * Assumes a 32-bit APB register bus and sixteen port pins.
 */
package gpp_pkg;

    localparam int unsigned PIN_COUNT = 16;
    localparam int unsigned ADDR_WIDTH = 12;
    localparam int unsigned DATA_WIDTH = 32;

    // Register byte offsets
    localparam logic [11:0] OFS_FUNC_SEL = 12'h418;
    localparam logic [11:0] OFS_DIR_CFG = 12'h41c;
    localparam logic [11:0] OFS_DATA_VAL = 12'h420;

    // Field layout: one live field in the low half of each word
    localparam int unsigned FIELD_LSB = 0;
    localparam int unsigned FIELD_MSB = 15;

    // Reset values
    localparam logic [15:0] RST_FUNC_SEL = 16'h0000;
    localparam logic [15:0] RST_DIR_CFG = 16'h0000;
    localparam logic [15:0] RST_DATA_OUT = 16'h0000;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

    // Input synchroniser depth
    localparam int unsigned SYNC_STAGES = 3;

    // Drive towards the pads; output enables are low while driving
    typedef struct packed {
        logic [15:0] level;
        logic [15:0] oe_n;
    } gpp_pad_out_t;

    // Drive requested by the alternate function logic
    typedef struct packed {
        logic [15:0] level;
        logic [15:0] drive;
    } gpp_alt_out_t;

endpackage : gpp_pkg

// ---- design/gpp_port.sv ----
/*
 * Sixteen-pin general purpose I/O port with an APB register slave.
 * Each pin is either plain I/O or handed to alternate function logic.
 * Assumes a single 10 MHz pclk and that presetn is the fundamental
 * reset; lesser resets are not wired to this block.
 */
// Design decision made here: register access over APB.
// How it works
// - One select bit per pin picks alternate
// - Zero select means plain I/O, resets zero
// - Direction bit set drives pin as output
// - Direction zero means input, resets zero
// - Alternate pins ignore direction bit entirely
// - Data read returns live level of pins
// - Data write changes plain output pins only
`timescale 1ns/100ps
module gpp_port #(
    parameter int unsigned PINS = gpp_pkg::PIN_COUNT
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [gpp_pkg::ADDR_WIDTH-1:0] paddr,
    input wire logic [gpp_pkg::DATA_WIDTH-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [gpp_pkg::DATA_WIDTH-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pads
    input wire logic [PINS-1:0] pad_in,
    output gpp_pkg::gpp_pad_out_t pad_out,
    // Alternate function logic
    input wire gpp_pkg::gpp_alt_out_t alt_out,
    output logic [PINS-1:0] alt_in,
    output logic [PINS-1:0] alt_sel
);

    logic [15:0] func_sel_q;
    logic [15:0] dir_cfg_q;
    logic [15:0] data_out_q;
    logic [15:0] pin_level;
    logic [15:0] oe_n_d;
    logic [15:0] lvl_d;
    logic [31:0] rdata_d;
    logic [1:0] lo_strb;
    logic access;
    logic wr_en;
    logic rd_en;
    gpp_pkg::gpp_pad_out_t pad_q;
    logic [31:0] prdata_q;
    logic [15:0] alt_in_q;
    logic pready_q;
    logic pslverr_q;

    // Zero-wait slave: the access phase ends in its first cycle
    assign access = psel && penable;
    assign wr_en = access && pwrite;
    assign rd_en = access && !pwrite;
    assign lo_strb = pstrb[1:0];

    gpp_pin_sync #(
        .WIDTH(16)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_raw(pad_in[15:0]),
        .pin_level(pin_level)
    );

    function automatic logic [15:0] merge_lanes(
        input logic [15:0] old_v,
        input logic [31:0] wd,
        input logic [1:0] st
    );
        logic [15:0] r;
        r = old_v;
        if (st[0]) begin
            r[7:0] = wd[7:0];
        end
        if (st[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction : merge_lanes

    // Only presetn clears these; a lesser reset must not reach them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            func_sel_q <= gpp_pkg::RST_FUNC_SEL;
        end else if (wr_en && paddr == gpp_pkg::OFS_FUNC_SEL) begin
            func_sel_q <= merge_lanes(func_sel_q, pwdata, lo_strb);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_cfg_q <= gpp_pkg::RST_DIR_CFG;
        end else if (wr_en && paddr == gpp_pkg::OFS_DIR_CFG) begin
            dir_cfg_q <= merge_lanes(dir_cfg_q, pwdata, lo_strb);
        end
    end

    // Written value lands only on plain-mode outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_out_q <= gpp_pkg::RST_DATA_OUT;
        end else if (wr_en && paddr == gpp_pkg::OFS_DATA_VAL) begin
            data_out_q <= (merge_lanes(data_out_q, pwdata, lo_strb)
                           & ~func_sel_q & dir_cfg_q)
                          | (data_out_q & (func_sel_q | ~dir_cfg_q));
        end
    end

    // Pad drive per pin
    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_pin
            always_comb begin
                if (func_sel_q[i]) begin
                    oe_n_d[i] = ~alt_out.drive[i];
                    lvl_d[i] = alt_out.level[i];
                end else begin
                    oe_n_d[i] = ~dir_cfg_q[i];
                    lvl_d[i] = data_out_q[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_q.oe_n <= 16'hffff;
            pad_q.level <= 16'h0000;
        end else begin
            pad_q.oe_n <= oe_n_d;
            pad_q.level <= lvl_d;
        end
    end

    // Sensed levels go to the alternate logic on every pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt_in_q <= 16'h0000;
        end else begin
            alt_in_q <= pin_level;
        end
    end

    // Read mux; upper half always zero
    always_comb begin
        rdata_d = gpp_pkg::RD_UNMAPPED;
        unique case (paddr)
            gpp_pkg::OFS_FUNC_SEL: rdata_d = {16'h0000, func_sel_q};
            gpp_pkg::OFS_DIR_CFG: rdata_d = {16'h0000, dir_cfg_q};
            gpp_pkg::OFS_DATA_VAL: rdata_d = {16'h0000, pin_level};
            default: rdata_d = gpp_pkg::RD_UNMAPPED;
        endcase
    end

    // Read data registered in the setup cycle, valid in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= rdata_d;
        end else if (rd_en) begin
            prdata_q <= prdata_q;
        end
    end

    // Held high from reset: the slave never inserts wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b1;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= 1'b1;
            pslverr_q <= 1'b0;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pad_out = pad_q;
    assign alt_in = alt_in_q;
    assign alt_sel = func_sel_q;

endmodule : gpp_port

// ---- tb/general_purpose_io_port_tb_top.sv ----
/* Register-level bench for the I/O port.
   Assumes the board model closes the pin loop. */
`timescale 1ns/100ps
module general_purpose_io_port_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [15:0] pad_in, alt_in, alt_sel, board_lvl, exp_pins;
    gpp_pkg::gpp_pad_out_t pad_out;
    gpp_pkg::gpp_alt_out_t alt_out;
    int bad_count, checks;
    logic hung;
    gpp_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
        .alt_out(alt_out), .alt_in(alt_in), .alt_sel(alt_sel));
    gpp_board_model u_board (.pad_out(pad_out), .board_lvl(board_lvl), .pad_in(pad_in));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task give_verdict;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // Bounded wait, though the slave never stalls
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        // After a hang every later transfer is skipped on the way to the report
        if (hung) begin
            return;
        end
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            bad_count++;
            hung = 1'b1;
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb, presetn} = '0;
        alt_out = '0;
        board_lvl = 16'h3c3c;
        bad_count = 0;
        checks = 0;
        hung = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        chk("oe_n reset", {16'h0, pad_out.oe_n}, 32'h0000_ffff);
        apb(1'b0, gpp_pkg::OFS_FUNC_SEL, 32'h0, 4'h0);
        chk("select reset", rd, 32'h0);
        apb(1'b0, gpp_pkg::OFS_DIR_CFG, 32'h0, 4'h0);
        chk("direction reset", rd, 32'h0);
        apb(1'b1, 12'h424, 32'hffff_ffff, 4'hf);
        apb(1'b0, 12'h424, 32'h0, 4'h0);
        chk("unmapped", rd, 32'h0);
        apb(1'b1, gpp_pkg::OFS_FUNC_SEL, 32'hffff_00ff, 4'hf);
        apb(1'b0, gpp_pkg::OFS_FUNC_SEL, 32'h0, 4'h0);
        chk("select", rd, 32'h0000_00ff);
        chk("alt_sel", {16'h0, alt_sel}, 32'h0000_00ff);
        alt_out <= {16'h0001, 16'h0003};
        apb(1'b1, gpp_pkg::OFS_DIR_CFG, 32'h0000_0f0f, 4'hf);
        apb(1'b1, gpp_pkg::OFS_DATA_VAL, 32'h0000_a5a5, 4'hf);
        repeat (10) @(posedge pclk);
        chk("oe_n", {16'h0, pad_out.oe_n}, 32'h0000_f0fc);
        chk("level", {16'h0, pad_out.level & 16'h0f03}, 32'h0000_0501);
        exp_pins = 16'h0501 | (board_lvl & 16'hf0fc);
        apb(1'b0, gpp_pkg::OFS_DATA_VAL, 32'h0, 4'h0);
        chk("pins", rd, {16'h0, exp_pins});
        chk("alt_in", {16'h0, alt_in}, {16'h0, exp_pins});
        // Upper lane only: low output byte must stay put
        board_lvl <= 16'hc3c3;
        apb(1'b1, gpp_pkg::OFS_DATA_VAL, 32'h0000_5aff, 4'h2);
        repeat (10) @(posedge pclk);
        exp_pins = 16'h0a01 | (board_lvl & 16'hf0fc);
        apb(1'b0, gpp_pkg::OFS_DATA_VAL, 32'h0, 4'h0);
        chk("pins lane", rd, {16'h0, exp_pins});
        chk("bus answer", {30'h0, pready, pslverr}, 32'h0000_0002);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        chk("oe_n rereset", {16'h0, pad_out.oe_n}, 32'h0000_ffff);
        apb(1'b0, gpp_pkg::OFS_FUNC_SEL, 32'h0, 4'h0);
        chk("select rereset", rd, 32'h0);
        give_verdict();
    end
endmodule : general_purpose_io_port_tb_top

// ---- tb/gpp_board_model.sv ----
/* Board model: drives every pin the port leaves undriven.
   Assumes no pin is left floating on the board. */
`timescale 1ns/100ps
module gpp_board_model (
    // From port and bench
    input wire gpp_pkg::gpp_pad_out_t pad_out,
    input wire logic [15:0] board_lvl,
    // Resolved wire
    output logic [15:0] pad_in
);
    // Port wins where it drives; board elsewhere
    assign pad_in = (~pad_out.oe_n & pad_out.level) | (pad_out.oe_n & board_lvl);
endmodule : gpp_board_model

// ---- tb/gpp_port_asserts.sv ----
/* Port checker for the I/O port.
   Sees only top ports; bound to the port below. */
`timescale 1ns/100ps
module gpp_port_asserts #(
    parameter int unsigned PINS = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pads and alternate logic
    input wire logic [PINS-1:0] pad_in,
    input wire gpp_pkg::gpp_pad_out_t pad_out,
    input wire gpp_pkg::gpp_alt_out_t alt_out,
    input wire logic [PINS-1:0] alt_in,
    input wire logic [PINS-1:0] alt_sel
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire fn_any = psel && penable && pwrite && paddr == gpp_pkg::OFS_FUNC_SEL;
    wire fn_wr = fn_any && pstrb[1:0] == 2'b11;
    sequence s_fn_wr;
        fn_wr;
    endsequence
    no_wait_a: assert property (pready && !pslverr)
        else $error("bus waited or erred");
    upper_zero_a: assert property (psel && penable && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    sel_reset_a: assert property ($rose(presetn) |-> alt_sel == 16'h0000)
        else $error("select not zero after reset");
    oe_reset_a: assert property ($rose(presetn) |-> pad_out.oe_n == 16'hffff)
        else $error("pins driven after reset");
    sel_write_a: assert property (s_fn_wr |=> alt_sel == $past(pwdata[15:0]))
        else $error("select write lost");
    sel_hold_a: assert property (!fn_any |=> $stable(alt_sel))
        else $error("select changed without write");
    // Pad outputs are registered, so compare against the previous cycle
    alt_drive_a: assert property (1'b1 |=> ((pad_out.oe_n ^ ~$past(alt_out.drive))
        & $past(alt_sel)) == 16'h0000)
        else $error("alternate pin enable wrong");
    pin_follow_a: assert property ($stable(pad_in)[*8] |-> alt_in == pad_in)
        else $error("pin level not followed");
endmodule : gpp_port_asserts
bind gpp_port gpp_port_asserts #(.PINS(PINS)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
    .pad_out(pad_out), .alt_out(alt_out), .alt_in(alt_in), .alt_sel(alt_sel));
